//--- power_control_pkg.sv
// Purpose: constants and types shared by the power control register bank
// Assumes: 32-bit AHB-Lite slave, single word transfers
// Notes: registers are decoded on the full 32-bit address, not on offsets
package power_control_pkg;
  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [31:0] POWER_CONTROL_ADDR = 32'h4000_7000;
  localparam logic [31:0] POWER_CONTROL_STATUS_ADDR = 32'h4000_7004;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4000_7008;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_700C;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int BACKUP_WRITE_ENABLE_BIT = 8;
  localparam int THRESHOLD_MSB = 7;
  localparam int THRESHOLD_LSB = 5;
  localparam int SUPPLY_MONITOR_ENABLE_BIT = 4;
  localparam int STANDBY_FLAG_CLEAR_BIT = 3;
  localparam int WAKE_FLAG_CLEAR_BIT = 2;
  localparam int DEEP_POWER_SELECT_BIT = 1;
  localparam int REGULATOR_LOW_POWER_BIT = 0;
  localparam int WAKE_PIN_ENABLE_BIT = 8;
  localparam int SUPPLY_BELOW_BIT = 2;
  localparam int STANDBY_FLAG_BIT = 1;
  localparam int WAKE_FLAG_BIT = 0;
  localparam int IRQ_WIDTH = 3;

  // -------------------------------------------------------------------------
  // bus constants
  // -------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] STOP_STANDBY_DELAY = 2'h1;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_STOP_WAIT = 2'b01,
    MODE_STOP = 2'b10,
    MODE_STANDBY = 2'b11
  } power_mode_e;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_s;

  typedef struct packed {
    logic backup_write_allow;
    logic supply_monitor_on;
    logic [2:0] supply_threshold_select;
    logic enter_standby;
    logic enter_stop;
    logic regulator_low_power_out;
    logic wake_pin_pulldown;
    logic wake_pin_wakeup_en;
  } power_ctl_s;
endpackage : power_control_pkg

//--- power_control_register_bank.sv
// Purpose: power control register bank on an AHB-Lite slave port
// Assumes: events arrive synchronous to clk; hready is the bus ready
// Notes: zero wait state slave, always OKAY
// What this block does
// - backup write enable bit 8 lets backup register writes through.
// - threshold select bits 7..5 choose one of eight rising monitor thresholds.
// - supply monitor enable bit 4 switches the supply detector on or off.
// - writing one to bit 3 clears the standby flag; zero does nothing.
// - both clear bits always read back as zero.
// - writing one to bit 2 clears the wake flag within two cycles.
// - deep power select bit 1 picks standby over stop on deep sleep.
// - regulator low power bit 0 sets low-power regulator during stop.
// - standby flag sets on standby entry and holds until cleared.
// - wake flag sets on pin or alarm wakeup and holds until cleared.
// - stop entry waits for flash programming and bus access to finish.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module power_control_register_bank (
  input wire logic clk,
  input wire logic rstn,
  input wire power_control_pkg::ahb_req_s ahb_req,
  output power_control_pkg::ahb_rsp_s ahb_rsp,
  input wire logic deep_sleep_request,
  input wire logic wait_for_interrupt,
  input wire logic flash_busy,
  input wire logic periph_bus_busy,
  input wire logic comparator_below,
  input wire logic wake_pin,
  input wire logic alarm_event,
  input wire logic backup_write_request,
  output logic backup_write_strobe,
  output power_control_pkg::power_ctl_s power_ctl,
  output logic [1:0] power_mode,
  output logic irq
);
  import power_control_pkg::*;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic backup_write_enable;
    logic [2:0] supply_threshold_select;
    logic supply_monitor_enable;
    logic deep_power_select;
    logic regulator_low_power;
    logic wake_pin_enable;
    logic supply_below_threshold;
    logic standby_flag;
    logic wake_flag;
    logic wake_pin_prev;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    power_mode_e mode;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic addr_take;
  logic wr_cur;
  logic standby_entry;
  logic stop_entry;
  logic wake_event;
  logic below_rise;
  logic [IRQ_WIDTH-1:0] irq_events;
  logic [31:0] control_view;
  logic [31:0] status_view;

  // reset release through two flops; assertion is immediate
  // kept apart from the state struct: it runs on the raw pin reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // -------------------------------------------------------------------------
  // event decode
  // -------------------------------------------------------------------------
  // address phase is taken whenever hready is high and a transfer is selected
  assign addr_take = ahb_req.hsel && ahb_req.hready &&
                     (ahb_req.htrans == HTRANS_NONSEQ || ahb_req.htrans == HTRANS_SEQ);
  assign wr_cur = state_reg.wr_pend;
  // stop waits on flash and bus activity; standby is taken at once
  assign stop_entry = state_reg.mode == MODE_STOP_WAIT && !flash_busy &&
                      !periph_bus_busy;
  assign standby_entry = state_reg.mode == MODE_RUN && deep_sleep_request &&
                         wait_for_interrupt && state_reg.deep_power_select;
  // rising edge of the pin counts only while the pin is enabled for wakeup
  assign wake_event = (state_reg.wake_pin_enable && wake_pin && !state_reg.wake_pin_prev) ||
                      alarm_event;
  assign below_rise = state_reg.supply_monitor_enable && comparator_below &&
                      !state_reg.supply_below_threshold;
  assign irq_events = {below_rise, standby_entry, wake_event};

  // read views: clear bits and reserved bits always read zero
  always_comb begin
    control_view = READ_ZERO;
    control_view[BACKUP_WRITE_ENABLE_BIT] = state_reg.backup_write_enable;
    control_view[THRESHOLD_MSB:THRESHOLD_LSB] = state_reg.supply_threshold_select;
    control_view[SUPPLY_MONITOR_ENABLE_BIT] = state_reg.supply_monitor_enable;
    control_view[STANDBY_FLAG_CLEAR_BIT] = 1'b0;
    control_view[WAKE_FLAG_CLEAR_BIT] = 1'b0;
    control_view[DEEP_POWER_SELECT_BIT] = state_reg.deep_power_select;
    control_view[REGULATOR_LOW_POWER_BIT] = state_reg.regulator_low_power;
    status_view = READ_ZERO;
    status_view[WAKE_PIN_ENABLE_BIT] = state_reg.wake_pin_enable;
    status_view[SUPPLY_BELOW_BIT] = state_reg.supply_below_threshold;
    status_view[STANDBY_FLAG_BIT] = state_reg.standby_flag;
    status_view[WAKE_FLAG_BIT] = state_reg.wake_flag;
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic wr_ctl;
    logic wr_sts;
    logic wr_irq;
    logic wr_msk;
    wr_ctl = wr_cur && state_reg.wr_addr == POWER_CONTROL_ADDR;
    wr_sts = wr_cur && state_reg.wr_addr == POWER_CONTROL_STATUS_ADDR;
    wr_irq = wr_cur && state_reg.wr_addr == IRQ_STATUS_ADDR;
    wr_msk = wr_cur && state_reg.wr_addr == IRQ_MASK_ADDR;
    state_next = state_reg;
    state_next.wr_pend = addr_take && ahb_req.hwrite;
    state_next.wr_addr = addr_take ? ahb_req.haddr : state_reg.wr_addr;
    state_next.wake_pin_prev = wake_pin;
    // read data is latched at the address phase so it stands in the data phase
    if (addr_take && !ahb_req.hwrite) begin
      unique case (ahb_req.haddr)
        POWER_CONTROL_ADDR: state_next.rdata = control_view;
        POWER_CONTROL_STATUS_ADDR: state_next.rdata = status_view;
        IRQ_STATUS_ADDR: state_next.rdata = {{(32-IRQ_WIDTH){1'b0}}, state_reg.irq_status};
        IRQ_MASK_ADDR: state_next.rdata = {{(32-IRQ_WIDTH){1'b0}}, state_reg.irq_mask};
        default: state_next.rdata = READ_ZERO;
      endcase
    end
    if (wr_ctl) begin
      state_next.backup_write_enable = ahb_req.hwdata[BACKUP_WRITE_ENABLE_BIT];
      state_next.supply_threshold_select =
        ahb_req.hwdata[THRESHOLD_MSB:THRESHOLD_LSB];
      state_next.supply_monitor_enable = ahb_req.hwdata[SUPPLY_MONITOR_ENABLE_BIT];
      state_next.deep_power_select = ahb_req.hwdata[DEEP_POWER_SELECT_BIT];
      state_next.regulator_low_power = ahb_req.hwdata[REGULATOR_LOW_POWER_BIT];
    end
    if (wr_sts) begin
      state_next.wake_pin_enable = ahb_req.hwdata[WAKE_PIN_ENABLE_BIT];
    end
    // monitor output follows the comparator only while the monitor is on
    state_next.supply_below_threshold = state_reg.supply_monitor_enable &&
                                        comparator_below;
    // flags: a clear write drops the flag, a same-cycle set wins
    if (wr_ctl && ahb_req.hwdata[STANDBY_FLAG_CLEAR_BIT]) begin
      state_next.standby_flag = 1'b0;
    end
    if (standby_entry) begin
      state_next.standby_flag = 1'b1;
    end
    if (wr_ctl && ahb_req.hwdata[WAKE_FLAG_CLEAR_BIT]) begin
      state_next.wake_flag = 1'b0;
    end
    if (wake_event) begin
      state_next.wake_flag = 1'b1;
    end
    // interrupt status: write one to clear, events win
    if (wr_irq) begin
      state_next.irq_status = state_reg.irq_status & ~ahb_req.hwdata[IRQ_WIDTH-1:0];
    end
    state_next.irq_status = state_next.irq_status | irq_events;
    if (wr_msk) begin
      state_next.irq_mask = ahb_req.hwdata[IRQ_WIDTH-1:0];
    end
    // low power mode sequencing
    unique case (state_reg.mode)
      MODE_RUN: begin
        if (standby_entry) begin
          state_next.mode = MODE_STANDBY;
        end else if (deep_sleep_request && wait_for_interrupt) begin
          state_next.mode = MODE_STOP_WAIT;
        end
      end
      MODE_STOP_WAIT: begin
        if (stop_entry) begin
          state_next.mode = MODE_STOP;
        end
      end
      MODE_STOP: begin
        if (wake_event || !deep_sleep_request) begin
          state_next.mode = MODE_RUN;
        end
      end
      MODE_STANDBY: begin
        if (wake_event) begin
          state_next.mode = MODE_RUN;
        end
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // registers: all writable bits reset to zero
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.wr_pend <= 1'b0;
      state_reg.wr_addr <= REG_RESET;
      state_reg.rdata <= REG_RESET;
      state_reg.backup_write_enable <= 1'b0;
      state_reg.supply_threshold_select <= 3'h0;
      state_reg.supply_monitor_enable <= 1'b0;
      state_reg.deep_power_select <= 1'b0;
      state_reg.regulator_low_power <= 1'b0;
      state_reg.wake_pin_enable <= 1'b0;
      state_reg.supply_below_threshold <= 1'b0;
      state_reg.standby_flag <= 1'b0;
      state_reg.wake_flag <= 1'b0;
      state_reg.wake_pin_prev <= 1'b0;
      state_reg.irq_status <= '0;
      state_reg.irq_mask <= '0;
      state_reg.mode <= MODE_RUN;
    end else begin
      state_reg.wr_pend <= state_next.wr_pend;
      state_reg.wr_addr <= state_next.wr_addr;
      state_reg.rdata <= state_next.rdata;
      state_reg.backup_write_enable <= state_next.backup_write_enable;
      state_reg.supply_threshold_select <= state_next.supply_threshold_select;
      state_reg.supply_monitor_enable <= state_next.supply_monitor_enable;
      state_reg.deep_power_select <= state_next.deep_power_select;
      state_reg.regulator_low_power <= state_next.regulator_low_power;
      state_reg.wake_pin_enable <= state_next.wake_pin_enable;
      state_reg.supply_below_threshold <= state_next.supply_below_threshold;
      state_reg.standby_flag <= state_next.standby_flag;
      state_reg.wake_flag <= state_next.wake_flag;
      state_reg.wake_pin_prev <= state_next.wake_pin_prev;
      state_reg.irq_status <= state_next.irq_status;
      state_reg.irq_mask <= state_next.irq_mask;
      state_reg.mode <= state_next.mode;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign ahb_rsp.hrdata = state_reg.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;
  assign backup_write_strobe = backup_write_request && state_reg.backup_write_enable;
  assign power_ctl.backup_write_allow = state_reg.backup_write_enable;
  assign power_ctl.supply_monitor_on = state_reg.supply_monitor_enable;
  assign power_ctl.supply_threshold_select = state_reg.supply_threshold_select;
  assign power_ctl.enter_standby = state_reg.mode == MODE_STANDBY;
  assign power_ctl.enter_stop = state_reg.mode == MODE_STOP;
  assign power_ctl.regulator_low_power_out = state_reg.mode == MODE_STOP &&
                                             state_reg.regulator_low_power;
  assign power_ctl.wake_pin_pulldown = state_reg.wake_pin_enable;
  assign power_ctl.wake_pin_wakeup_en = state_reg.wake_pin_enable;
  assign power_mode = state_reg.mode;
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  AST_BACKUP_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    backup_write_strobe |-> state_reg.backup_write_enable)
    else $error("backup write passed while disabled");
  AST_CLEAR_READS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_take && !ahb_req.hwrite && ahb_req.haddr == POWER_CONTROL_ADDR) |=>
    (ahb_rsp.hrdata[STANDBY_FLAG_CLEAR_BIT] == 1'b0) &&
    (ahb_rsp.hrdata[WAKE_FLAG_CLEAR_BIT] == 1'b0))
    else $error("clear bit read as one");
  AST_WAKE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.wr_pend && state_reg.wr_addr == POWER_CONTROL_ADDR &&
     ahb_req.hwdata[WAKE_FLAG_CLEAR_BIT] && !wake_event) |=> ##[0:1] !state_reg.wake_flag)
    else $error("wake flag not cleared in two cycles");
  AST_STANDBY_SET: assert property (@(posedge clk) disable iff (!rst_n)
    standby_entry |=> state_reg.standby_flag && state_reg.mode == MODE_STANDBY)
    else $error("standby entry did not set flag");
  AST_WAKE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    wake_event |=> state_reg.wake_flag)
    else $error("wake event lost");
  AST_STANDBY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(state_reg.standby_flag)) |-> $past(state_reg.wr_pend))
    else $error("standby flag fell without a write");
  AST_STOP_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.mode == MODE_STOP_WAIT && flash_busy) |=> state_reg.mode != MODE_STOP)
    else $error("stop entered during flash programming");
  AST_BELOW_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg.supply_monitor_enable && comparator_below) |=> state_reg.supply_below_threshold)
    else $error("below flag not set");
  AST_REG_LOW_POWER: assert property (@(posedge clk) disable iff (!rst_n)
    power_ctl.regulator_low_power_out |-> state_reg.mode == MODE_STOP)
    else $error("low power regulator outside stop");
endmodule : power_control_register_bank
`default_nettype wire

//--- power_control_register_bank_tb.sv
// Purpose: self-checking bench for the power control register bank
// Assumes: zero wait state slave whose hreadyout is fed back as hready
// Notes: sleep entry is driven through the core-side level inputs
`timescale 1ns/1ps
`default_nettype none
module power_control_register_bank_tb;
  import power_control_pkg::*;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic deep_sleep_request = 1'b0;
  logic wait_for_interrupt = 1'b0;
  logic flash_busy = 1'b0;
  logic periph_bus_busy = 1'b0;
  logic comparator_below = 1'b0;
  logic wake_pin = 1'b0;
  logic alarm_event = 1'b0;
  logic backup_write_request = 1'b0;
  ahb_req_s ahb_req;
  ahb_rsp_s ahb_rsp;
  logic backup_write_strobe;
  power_ctl_s power_ctl;
  logic [1:0] power_mode;
  logic irq;
  logic [31:0] rd;
  int error_cnt = 0;
  int total_checks = 0;

  // single slave: its ready is the bus ready
  assign ahb_req = '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: hsize,
                     hsel: hsel, hready: ahb_rsp.hreadyout, hwdata: hwdata};

  power_control_register_bank power_control_register_bank_i (
    .clk(clk),
    .rstn(rstn),
    .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp),
    .deep_sleep_request(deep_sleep_request),
    .wait_for_interrupt(wait_for_interrupt),
    .flash_busy(flash_busy),
    .periph_bus_busy(periph_bus_busy),
    .comparator_below(comparator_below),
    .wake_pin(wake_pin),
    .alarm_event(alarm_event),
    .backup_write_request(backup_write_request),
    .backup_write_strobe(backup_write_strobe),
    .power_ctl(power_ctl),
    .power_mode(power_mode),
    .irq(irq)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for hready; a hung bus ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
    if (ahb_rsp.hreadyout !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: ready seen %h expected %h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask : wait_ready

  // one single-word transfer; read data is taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = ahb_rsp.hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // mode changes are bounded so a stuck state machine cannot hang the run
  task automatic wait_mode(input logic [1:0] m);
    int n;
    for (n = 0; n < 40 && power_mode !== m; n++) begin
      @(posedge clk);
    end
    check({30'h0, power_mode}, {30'h0, m});
    // a mode that never arrives ends the run
    if (power_mode !== m) begin
      close_out();
    end
  endtask : wait_mode

  task automatic pulse_alarm();
    alarm_event <= 1'b1;
    @(posedge clk);
    alarm_event <= 1'b0;
  endtask : pulse_alarm

  // ---------------------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: run limit seen %h expected %h", $time, 1'b1, 1'b0);
    close_out();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int i;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    // reset values, reserved bits and an unmapped word
    rdchk(POWER_CONTROL_ADDR, REG_RESET);
    rdchk(POWER_CONTROL_STATUS_ADDR, REG_RESET);
    rdchk(IRQ_MASK_ADDR, REG_RESET);
    rdchk(32'h4000_7010, READ_ZERO);
    check({31'h0, ahb_rsp.hresp}, 32'h0000_0000);
    wr(POWER_CONTROL_ADDR, 32'hffff_ffff);
    rdchk(POWER_CONTROL_ADDR, 32'h0000_01f3);
    check({31'h0, power_ctl.supply_monitor_on}, 32'h0000_0001);
    // low-power regulator only applies in stop, not while running
    check({31'h0, power_ctl.regulator_low_power_out}, 32'h0000_0000);
    backup_write_request <= 1'b1;
    tick(1);
    check({31'h0, backup_write_strobe}, 32'h0000_0001);
    check({31'h0, power_ctl.backup_write_allow}, 32'h0000_0001);
    wr(POWER_CONTROL_ADDR, 32'h0000_0000);
    // the write lands on the edge the task returns at; let it settle
    tick(1);
    check({31'h0, backup_write_strobe}, 32'h0000_0000);
    check({31'h0, power_ctl.supply_monitor_on}, 32'h0000_0000);
    backup_write_request <= 1'b0;
    // every threshold code, lowest to highest
    for (i = 0; i < 8; i++) begin
      wr(POWER_CONTROL_ADDR, 32'(i) << THRESHOLD_LSB);
      rdchk(POWER_CONTROL_ADDR, 32'(i) << THRESHOLD_LSB);
      check({29'h0, power_ctl.supply_threshold_select}, 32'(i));
    end
    wr(POWER_CONTROL_STATUS_ADDR, 32'hffff_ffff);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0100);
    check({31'h0, power_ctl.wake_pin_pulldown}, 32'h0000_0001);
    check({31'h0, power_ctl.wake_pin_wakeup_en}, 32'h0000_0001);
    wr(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    $display("test registers done");
    // a pin edge is ignored while the pin is general purpose
    wake_pin <= 1'b1;
    tick(3);
    wake_pin <= 1'b0;
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    wr(POWER_CONTROL_STATUS_ADDR, 32'h0000_0100);
    wake_pin <= 1'b1;
    tick(3);
    wake_pin <= 1'b0;
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0101);
    wr(POWER_CONTROL_ADDR, 32'h0000_0000);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0101);
    wr(POWER_CONTROL_ADDR, 32'h0000_0004);
    tick(2);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0100);
    pulse_alarm();
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0101);
    wr(POWER_CONTROL_ADDR, 32'h0000_0004);
    // interrupt: masked, unmasked, then cleared by writing one
    rdchk(IRQ_STATUS_ADDR, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0001);
    tick(1);
    check({31'h0, irq}, 32'h0000_0001);
    wr(IRQ_STATUS_ADDR, 32'h0000_0001);
    tick(1);
    check({31'h0, irq}, 32'h0000_0000);
    wr(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    $display("test wake done");
    // standby entry, alarm wake, sticky flag and its clear bit
    wr(POWER_CONTROL_ADDR, 32'h0000_0002);
    deep_sleep_request <= 1'b1;
    wait_for_interrupt <= 1'b1;
    wait_mode(MODE_STANDBY);
    check({31'h0, power_ctl.enter_standby}, 32'h0000_0001);
    deep_sleep_request <= 1'b0;
    wait_for_interrupt <= 1'b0;
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0002);
    pulse_alarm();
    wait_mode(MODE_RUN);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0003);
    wr(POWER_CONTROL_ADDR, 32'h0000_0000);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0003);
    wr(POWER_CONTROL_ADDR, 32'h0000_0008);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0001);
    rdchk(IRQ_STATUS_ADDR, 32'h0000_0003);
    wr(POWER_CONTROL_ADDR, 32'h0000_0004);
    wr(IRQ_STATUS_ADDR, 32'h0000_0003);
    $display("test standby done");
    // stop entry is held off by flash and peripheral bus activity
    wr(POWER_CONTROL_ADDR, 32'h0000_0001);
    flash_busy <= 1'b1;
    deep_sleep_request <= 1'b1;
    wait_for_interrupt <= 1'b1;
    wait_mode(MODE_STOP_WAIT);
    tick(5);
    check({30'h0, power_mode}, {30'h0, MODE_STOP_WAIT});
    flash_busy <= 1'b0;
    periph_bus_busy <= 1'b1;
    tick(5);
    check({30'h0, power_mode}, {30'h0, MODE_STOP_WAIT});
    periph_bus_busy <= 1'b0;
    wait_mode(MODE_STOP);
    check({31'h0, power_ctl.enter_stop}, 32'h0000_0001);
    check({31'h0, power_ctl.regulator_low_power_out}, 32'h0000_0001);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    deep_sleep_request <= 1'b0;
    wait_for_interrupt <= 1'b0;
    wait_mode(MODE_RUN);
    $display("test stop done");
    // supply monitor flag follows the comparator only while enabled
    wr(POWER_CONTROL_ADDR, 32'h0000_0010);
    comparator_below <= 1'b1;
    tick(3);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0004);
    wr(IRQ_MASK_ADDR, 32'h0000_0004);
    tick(1);
    check({31'h0, irq}, 32'h0000_0001);
    comparator_below <= 1'b0;
    tick(3);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    wr(POWER_CONTROL_ADDR, 32'h0000_0000);
    comparator_below <= 1'b1;
    tick(3);
    rdchk(POWER_CONTROL_STATUS_ADDR, 32'h0000_0000);
    wr(IRQ_STATUS_ADDR, 32'h0000_0004);
    tick(1);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test supply done");
    close_out();
  end
endmodule : power_control_register_bank_tb
`default_nettype wire
